// ===== hdl/otp_sec_pkg.sv
// Shared constants and types for the secured OTP and security status block
package otp_sec_pkg;

    // Clock rate of the core clock, in kHz
    localparam int CLK_FREQ_KHZ  = 10000;
    // Wake-up delay out of deep sleep, in ns (plain default, no figure known)
    localparam int WAKE_DELAY_NS = 20000;
    // Wake-up delay in core cycles, least time so rounded up
    localparam int WAKE_CYCLES   = (WAKE_DELAY_NS * CLK_FREQ_KHZ + 999999) / 1000000;

    // Fixed opcodes
    localparam logic [7:0] OP_WAKE        = 8'hab;
    localparam logic [7:0] OP_DEEP        = 8'hb9;
    // Defaults for decoder opcodes that are implementation choices
    localparam logic [7:0] OP_WRITE_ENABLE_CMD_DEF    = 8'h15;
    localparam logic [7:0] OP_ENTER_DEF   = 8'h11;
    localparam logic [7:0] OP_EXIT_DEF    = 8'h12;
    localparam logic [7:0] OP_SREAD_DEF   = 8'h13;
    localparam logic [7:0] OP_SWRITE_DEF  = 8'h14;

    // Field positions of the status byte
    localparam int BIT_PROT  = 7;
    localparam int BIT_EFAIL = 6;
    localparam int BIT_PFAIL = 5;
    localparam int BIT_RSVD  = 4;
    localparam int BIT_ESUSP = 3;
    localparam int BIT_PSUSP = 2;
    localparam int BIT_CLOCK = 1;
    localparam int BIT_FLOCK = 0;

    // Opcode phase lengths in link clocks
    localparam logic [3:0] SPI_OP_CLKS = 4'h8;
    localparam logic [3:0] QPI_OP_CLKS = 4'h2;
    localparam logic [3:0] CNT_MAX     = 4'hf;
    localparam logic [2:0] SPI_LAST    = 3'h7;
    // Data line that carries serial output in single-wire mode
    localparam int SO_LINE = 1;

    // Power states
    typedef enum logic [1:0]
    {
        PWR_STANDBY = 2'b00,
        PWR_DEEP    = 2'b01,
        PWR_WAKING  = 2'b10
    } pwr_type;

endpackage : otp_sec_pkg

// ===== hdl/otp_sec_status.sv
// Secured OTP mode, wake command and security status register logic
//
// How it works
// - Wake completes when chip select rises
// - Wake outside deep sleep: standby immediately
// - Wake from deep sleep waits the wake delay
// - Wake opcode ABh, single or four-wire
// - Opcode 8 or 2 clocks; upper lines ignored
// - Standby waits for chip select before next
// - Enter-OTP retargets reads and programs to OTP
// - In OTP mode only OTP accessed
// - Locked OTP area refuses updates, allows reads
// - Exit-OTP returns to main-array access
// - Status read answered except in deep sleep or wake delay, repeating
// - Status byte shifted out until chip select rises
// - Status write sets customer lock, then frozen
// - Status write off byte boundary is rejected
// - Erase fail flag bit6 set/cleared by erases
// - Program fail flag bit5 set/cleared by programs
// - Erase suspended flag bit3 follows suspend/resume
// - Program suspended flag bit2 follows suspend/resume
// - Bit0 shows factory lock, read-only
// - Bit7 protection mode select, one-time, default zero
// - Deep sleep ignores all but wake
`timescale 1ns/100ps

module otp_sec_status
    import otp_sec_pkg::*;
#(
    parameter int         WAKE_CYC     = WAKE_CYCLES,
    parameter logic [7:0] OP_WRITE_ENABLE_CMD      = OP_WRITE_ENABLE_CMD_DEF,
    parameter logic [7:0] OP_ENTER_OTP = OP_ENTER_DEF,
    parameter logic [7:0] OP_EXIT_OTP  = OP_EXIT_DEF,
    parameter logic [7:0] OP_SEC_READ  = OP_SREAD_DEF,
    parameter logic [7:0] OP_SEC_WRITE = OP_SWRITE_DEF
)
(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic [3:0] SIO_IN,
    input  wire logic       QUAD_MODE,
    output logic      [3:0] SIO_OUT,
    output logic      [3:0] SIO_OE,
    input  wire logic       NV_CUST_LOCK,
    input  wire logic       NV_FACTORY_LOCK,
    input  wire logic       NV_PROT_MODE,
    input  wire logic       PROT_MODE_SET,
    input  wire logic       ERASE_DONE,
    input  wire logic       ERASE_OK,
    input  wire logic       PROG_DONE,
    input  wire logic       PROG_OK,
    input  wire logic       ERASE_SUSPEND,
    input  wire logic       ERASE_RESUME,
    input  wire logic       PROG_SUSPEND,
    input  wire logic       PROG_RESUME,
    input  wire logic       ARRAY_REQ,
    input  wire logic       ARRAY_WR,
    input  wire logic       ARRAY_OTP_HALF,
    output logic            ARRAY_GRANT,
    output logic            ARRAY_REFUSE,
    output logic            ARRAY_TO_OTP,
    output logic            DEEP_SLEEP,
    output logic            OTP_MODE,
    output logic            WRITE_EN_LATCH,
    output logic            CMD_REJECT,
    output logic      [7:0] SEC_STATUS
);

    // ---------------- Link side, clocked by SCLK ----------------
    logic       frame_rst_n;   // Low outside a frame or under reset
    logic [3:0] clk_cnt_r;     // Link clocks seen in this frame
    logic [7:0] shift_r;       // Opcode shifter
    logic [7:0] opcode_r;      // Last complete opcode, held between frames
    logic       op_tgl_r;      // Flips once per complete opcode
    logic       extra_r;       // Clocks seen past the opcode phase
    logic       read_act_r;    // Status read in progress
    logic [2:0] out_pos_r;     // Output bit or nibble position
    logic [7:0] stat_ls1_r;    // Status sync, first stage
    logic [7:0] stat_ls2_r;    // Status sync, second stage
    logic       deep_ls1_r;    // Deep sleep sync, first stage
    logic       deep_ls2_r;    // Deep sleep sync, second stage
    logic [3:0] sio_out_r;     // Output data, launched on falling edge
    logic [3:0] sio_oe_r;      // Output enables, launched on falling edge
    logic [3:0] op_len;        // Opcode phase length for current mode
    logic       op_edge;       // This rising edge completes the opcode
    logic [7:0] shift_nxt;     // Shifter value after this edge

    // Frame reset: chip select high clears the per-frame state at once
    assign frame_rst_n = NRST & ~CS_N;

    // Opcode phase length and the next shifter value
    always_comb
    begin
        op_len    = QUAD_MODE ? QPI_OP_CLKS : SPI_OP_CLKS;
        op_edge   = (clk_cnt_r == op_len - 4'h1);
        shift_nxt = QUAD_MODE ? {shift_r[3:0], SIO_IN}
                              : {shift_r[6:0], SIO_IN[0]};
    end

    // Per-frame shifting and counting; restarts with every frame
    always_ff @(posedge SCLK or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            clk_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            read_act_r <= 1'b0;
        end
        else
        begin
            shift_r <= shift_nxt;
            // Saturate so long frames do not wrap back to the opcode phase
            if (clk_cnt_r != CNT_MAX)
                clk_cnt_r <= clk_cnt_r + 4'h1;
            // Status read is honoured in any state but deep sleep and the wake delay
            if (op_edge && shift_nxt == OP_SEC_READ && !deep_ls2_r)
                read_act_r <= 1'b1;
        end
    end

    // Opcode hand-off to the core; these survive the frame end on purpose,
    // since the core may sample them after chip select has risen
    always_ff @(posedge SCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            opcode_r <= 8'h00;
            op_tgl_r <= 1'b0;
            extra_r  <= 1'b0;
        end
        else
        begin
            if (op_edge)
            begin
                opcode_r <= shift_nxt;
                op_tgl_r <= ~op_tgl_r;
            end
            // Cleared on the first clock of a frame, set past the opcode
            if (clk_cnt_r == 4'h0)
                extra_r <= 1'b0;
            else if (clk_cnt_r >= op_len)
                extra_r <= 1'b1;
        end
    end

    // Core state into the link domain; the link clock runs only in frames,
    // so the opcode phase flushes these before any data bit goes out
    always_ff @(posedge SCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            stat_ls1_r <= 8'h00;
            stat_ls2_r <= 8'h00;
            deep_ls1_r <= 1'b0;
            deep_ls2_r <= 1'b0;
        end
        else
        begin
            stat_ls1_r <= SEC_STATUS;
            stat_ls2_r <= stat_ls1_r;
            deep_ls1_r <= DEEP_SLEEP;
            deep_ls2_r <= deep_ls1_r;
        end
    end

    // Status byte out on falling edges, repeated until chip select rises
    always_ff @(negedge SCLK or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            out_pos_r <= 3'h0;
            sio_out_r <= 4'h0;
            sio_oe_r  <= 4'h0;
        end
        else if (read_act_r)
        begin
            out_pos_r <= out_pos_r + 3'h1;
            if (QUAD_MODE)
            begin
                // High nibble first, then low nibble
                sio_out_r <= out_pos_r[0] ? stat_ls2_r[3:0] : stat_ls2_r[7:4];
                sio_oe_r  <= 4'hf;
            end
            else
            begin
                // Most significant bit first on the serial output line
                sio_out_r          <= 4'h0;
                sio_out_r[SO_LINE] <= stat_ls2_r[3'(SPI_LAST - out_pos_r)];
                sio_oe_r           <= 4'h0;
                sio_oe_r[SO_LINE]  <= 1'b1;
            end
        end
    end

    assign SIO_OUT = sio_out_r;
    assign SIO_OE  = sio_oe_r;

    // ---------------- Core side, clocked by CLK ----------------
    logic       cs_s1_r, cs_s2_r, cs_d_r;    // Chip select synchroniser and delay
    logic       tgl_s1_r, tgl_s2_r, tgl_d_r; // Opcode toggle synchroniser
    logic       ext_s1_r, ext_s2_r;          // Overrun flag synchroniser
    logic       cs_rise_r;                   // Frame just ended
    logic       pend_r;                      // Opcode received, not yet acted on
    logic [7:0] cmd_r;                       // Captured opcode
    logic       exec;                        // Act on cmd_r this cycle
    logic       exact;                       // Frame ended on the opcode boundary
    pwr_type    pwr_r;                       // Power state
    logic [15:0] wake_cnt_r;                 // Wake delay countdown
    logic       otp_r;                       // OTP mode
    logic       wel_r;                       // Write-enable latch
    logic       nv_ld_r;                     // One-time bits loaded
    logic       prot_r, clock_r, flock_r;    // One-time bits
    logic       efail_r, pfail_r;            // Fail flags
    logic       esusp_r, psusp_r;            // Suspend flags
    logic       reject_r;                    // Command rejected pulse
    logic [7:0] status_r;                    // Assembled status byte
    logic       grant_r, refuse_r, to_otp_r; // Array access answer
    logic       deep_out_r;                  // Not yet in standby

    // Chip select, toggle and overrun cross with two flops each
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cs_s1_r  <= 1'b1;
            cs_s2_r  <= 1'b1;
            cs_d_r   <= 1'b1;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_d_r  <= 1'b0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end
        else
        begin
            cs_s1_r  <= CS_N;
            cs_s2_r  <= cs_s1_r;
            cs_d_r   <= cs_s2_r;
            tgl_s1_r <= op_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_d_r  <= tgl_s2_r;
            ext_s1_r <= extra_r;
            ext_s2_r <= ext_s1_r;
        end
    end

    // Capture the opcode, act on it three core edges after chip select rises
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cs_rise_r <= 1'b0;
            pend_r    <= 1'b0;
            cmd_r     <= 8'h00;
        end
        else
        begin
            cs_rise_r <= cs_s2_r & ~cs_d_r;
            // Opcode word is stable once its toggle has crossed
            if (tgl_s2_r != tgl_d_r)
            begin
                pend_r <= 1'b1;
                cmd_r  <= opcode_r;
            end
            else if (cs_rise_r)
                pend_r <= 1'b0;
        end
    end

    assign exec  = cs_rise_r & pend_r;
    assign exact = ~ext_s2_r;

    // Power state: deep sleep, wake delay, standby
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pwr_r      <= PWR_STANDBY;
            wake_cnt_r <= 16'h0000;
        end
        else
        begin
            case (pwr_r)
                PWR_STANDBY:
                begin
                    // A wake here changes nothing: standby is immediate
                    if (exec && cmd_r == OP_DEEP && exact)
                        pwr_r <= PWR_DEEP;
                end
                PWR_DEEP:
                begin
                    if (exec && cmd_r == OP_WAKE)
                    begin
                        pwr_r      <= PWR_WAKING;
                        wake_cnt_r <= 16'(WAKE_CYC - 1);
                    end
                end
                PWR_WAKING:
                begin
                    // Host keeps chip select high for the whole delay
                    if (wake_cnt_r == 16'h0000)
                        pwr_r <= PWR_STANDBY;
                    else
                        wake_cnt_r <= wake_cnt_r - 16'h0001;
                end
                default:
                    pwr_r <= PWR_STANDBY;
            endcase
        end
    end

    // Command effects in standby; deep sleep and waking ignore them all
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            otp_r    <= 1'b0;
            wel_r    <= 1'b0;
            reject_r <= 1'b0;
        end
        else
        begin
            reject_r <= 1'b0;
            if (exec && pwr_r != PWR_STANDBY && cmd_r != OP_WAKE)
                reject_r <= 1'b1;
            else if (exec && pwr_r == PWR_STANDBY)
            begin
                if (cmd_r == OP_WRITE_ENABLE_CMD)
                    wel_r <= 1'b1;
                else if (cmd_r == OP_ENTER_OTP)
                    otp_r <= 1'b1;
                else if (cmd_r == OP_EXIT_OTP)
                    otp_r <= 1'b0;
                else if (cmd_r == OP_SEC_WRITE)
                begin
                    // Off-boundary or without the latch: not performed
                    if (exact && wel_r)
                        wel_r <= 1'b0;
                    else
                        reject_r <= 1'b1;
                end
            end
        end
    end

    // One-time bits: power-up image loaded once, then only ever set
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            nv_ld_r <= 1'b0;
            prot_r  <= 1'b0;
            clock_r <= 1'b0;
            flock_r <= 1'b0;
        end
        else if (!nv_ld_r)
        begin
            nv_ld_r <= 1'b1;
            prot_r  <= NV_PROT_MODE;
            clock_r <= NV_CUST_LOCK;
            flock_r <= NV_FACTORY_LOCK;
        end
        else
        begin
            if (PROT_MODE_SET)
                prot_r <= 1'b1;
            if (exec && pwr_r == PWR_STANDBY && cmd_r == OP_SEC_WRITE && exact && wel_r)
                clock_r <= 1'b1;
        end
    end

    // Volatile fail and suspend flags; a set beats a same-cycle clear
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            efail_r <= 1'b0;
            pfail_r <= 1'b0;
            esusp_r <= 1'b0;
            psusp_r <= 1'b0;
        end
        else
        begin
            // Fail flags only report; nothing here stops an operation
            if (ERASE_DONE)
                efail_r <= ~ERASE_OK;
            if (PROG_DONE)
                pfail_r <= ~PROG_OK;
            if (ERASE_SUSPEND)
                esusp_r <= 1'b1;
            else if (ERASE_RESUME)
                esusp_r <= 1'b0;
            if (PROG_SUSPEND)
                psusp_r <= 1'b1;
            else if (PROG_RESUME)
                psusp_r <= 1'b0;
        end
    end

    // Status byte image, one cycle behind its bits
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            status_r <= 8'h00;
        else
        begin
            status_r[BIT_PROT]  <= prot_r;
            status_r[BIT_EFAIL] <= efail_r;
            status_r[BIT_PFAIL] <= pfail_r;
            status_r[BIT_RSVD]  <= 1'b0;
            status_r[BIT_ESUSP] <= esusp_r;
            status_r[BIT_PSUSP] <= psusp_r;
            status_r[BIT_CLOCK] <= clock_r;
            status_r[BIT_FLOCK] <= flock_r;
        end
    end

    // Array access steering; in OTP mode the main array is never reached
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            grant_r  <= 1'b0;
            refuse_r <= 1'b0;
            to_otp_r <= 1'b0;
        end
        else
        begin
            grant_r  <= 1'b0;
            refuse_r <= 1'b0;
            if (ARRAY_REQ)
            begin
                to_otp_r <= otp_r;
                // Writes into a locked half are refused, reads always pass
                if (otp_r && ARRAY_WR && (ARRAY_OTP_HALF ? flock_r : clock_r))
                    refuse_r <= 1'b1;
                else
                    grant_r <= 1'b1;
            end
        end
    end

    // Deep sleep indication covers the wake delay too
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            deep_out_r <= 1'b0;
        else
            deep_out_r <= (pwr_r != PWR_STANDBY);
    end

    assign ARRAY_GRANT    = grant_r;
    assign ARRAY_REFUSE   = refuse_r;
    assign ARRAY_TO_OTP   = to_otp_r;
    assign DEEP_SLEEP     = deep_out_r;
    assign OTP_MODE       = otp_r;
    assign WRITE_EN_LATCH = wel_r;
    assign CMD_REJECT     = reject_r;
    assign SEC_STATUS     = status_r;

    // ---------------- Checks ----------------
    wake_delay_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (pwr_r == PWR_WAKING && wake_cnt_r == 16'h0000) |=> pwr_r == PWR_STANDBY)
    else $error("wake delay did not end in standby");

    wake_start_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (exec && pwr_r == PWR_DEEP && cmd_r == OP_WAKE) |=> pwr_r == PWR_WAKING ##1 pwr_r == PWR_WAKING)
    else $error("wake from deep sleep skipped the delay");

    wake_instant_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (exec && pwr_r == PWR_STANDBY && cmd_r == OP_WAKE) |=> pwr_r == PWR_STANDBY)
    else $error("wake in standby left standby");

    deep_ignore_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (exec && pwr_r == PWR_DEEP && cmd_r != OP_WAKE) |=> $stable(otp_r) && $stable(wel_r) && reject_r)
    else $error("command acted on in deep sleep");

    lock_cause_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        ($past(nv_ld_r) && $rose(clock_r)) |-> $past(wel_r) && !wel_r)
    else $error("customer lock set without latch");

    lock_sticky_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (nv_ld_r && clock_r) |=> clock_r [*2])
    else $error("customer lock cleared");

    erase_fail_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (ERASE_DONE && !ERASE_OK) |=> efail_r ##1 status_r[BIT_EFAIL])
    else $error("erase fail flag not raised");

    prog_fail_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (PROG_DONE && PROG_OK) |=> !pfail_r)
    else $error("program fail flag not cleared");

    suspend_wins_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (ERASE_SUSPEND && ERASE_RESUME) |=> esusp_r)
    else $error("erase suspend lost to resume");

    otp_refuse_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        (ARRAY_REQ && ARRAY_WR && otp_r && !ARRAY_OTP_HALF && clock_r) |=> refuse_r && !grant_r && to_otp_r)
    else $error("write to locked OTP area passed");

    reserved_zero_a:
    assert property (@(posedge CLK) disable iff (!NRST)
        status_r[BIT_RSVD] == 1'b0)
    else $error("reserved status bit set");

endmodule : otp_sec_status

// ===== bench/host_model.sv
// Host model that frames opcodes and reads answers on the serial link
`timescale 1ns/100ps
module host_model
(
    output logic            SCLK,
    output logic            CS_N,
    output logic      [3:0] SIO_IN,
    input  wire logic [3:0] SIO_OUT
);
    // Clock parked low and chip deselected outside frames
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SIO_IN = 4'h5;
    end
    // One frame: opcode, then extra clocks whose output is gathered
    task automatic frame(input logic [7:0] op, input logic quad, input int extra, output logic [15:0] rd);
        int n;
        n = quad ? 2 : 8;
        rd = 16'h0;
        #37 CS_N = 1'b0;
        for (int i = 0; i < n + extra; i++)
        begin
            // Upper lines carry the inverse in single-wire mode
            if (i < n) SIO_IN = quad ? op[7-4*i -: 4] : {{3{~op[7-i]}}, op[7-i]};
            else SIO_IN = ~SIO_IN;
            #80 SCLK = 1'b1;
            if (i >= n) rd = quad ? {rd[11:0], SIO_OUT} : {rd[14:0], SIO_OUT[1]};
            #80 SCLK = 1'b0;
        end
        // Released lines toggle so no stale value survives
        #300 CS_N = 1'b1;
        SIO_IN = ~SIO_IN;
    endtask : frame
endmodule : host_model

// ===== bench/otp_sec_status_tb.sv
// Self-checking bench for the OTP and security status block
`timescale 1ns/100ps
module otp_sec_status_tb import otp_sec_pkg::*;;
    logic        CLK, NRST, QUAD_MODE, SCLK, CS_N, GRANT, REFUSE, TO_OTP, DEEP, OTPM, WRITE_ENABLE_LATCH, REJ, rej_seen;
    logic [11:0] ev;
    logic [3:0]  SIO_IN, SIO_OUT, SIO_OE;
    logic [7:0]  STAT;
    logic [15:0] rd;
    logic [2:0]  g;
    int          n;
    int          err_count = 0;
    int          tests_run = 0;
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    otp_sec_status #(.WAKE_CYC(3)) u_otp_sec_status (.CLK(CLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N),
        .SIO_IN(SIO_IN), .QUAD_MODE(QUAD_MODE), .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE), .NV_CUST_LOCK(1'b0),
        .NV_FACTORY_LOCK(1'b1), .NV_PROT_MODE(1'b0), .PROT_MODE_SET(ev[8]), .ERASE_DONE(ev[0]),
        .ERASE_OK(ev[1]), .PROG_DONE(ev[2]), .PROG_OK(ev[3]), .ERASE_SUSPEND(ev[4]), .ERASE_RESUME(ev[5]),
        .PROG_SUSPEND(ev[6]), .PROG_RESUME(ev[7]), .ARRAY_REQ(ev[9]), .ARRAY_WR(ev[10]),
        .ARRAY_OTP_HALF(ev[11]), .ARRAY_GRANT(GRANT), .ARRAY_REFUSE(REFUSE), .ARRAY_TO_OTP(TO_OTP),
        .DEEP_SLEEP(DEEP), .OTP_MODE(OTPM), .WRITE_EN_LATCH(WRITE_ENABLE_LATCH), .CMD_REJECT(REJ), .SEC_STATUS(STAT));
    host_model u_host_model (.SCLK(SCLK), .CS_N(CS_N), .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT));
    // Sticky copy of the one-cycle reject pulse; a frame in progress clears it
    always @(posedge CLK)
    begin
        if (CS_N === 1'b0)
            rej_seen <= 1'b0;
        else if (REJ === 1'b1)
            rej_seen <= 1'b1;
    end
    // Wait for k core edges, then move just past the last one
    task automatic step(int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask : step
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Pulse event inputs for one cycle and catch the array answer
    task automatic pls(logic [11:0] v);
        ev = v;
        step(1);
        g = {GRANT, REFUSE, TO_OTP};
        ev = 12'h0;
        step(3);
    endtask : pls
    // Frame then the idle gap that covers sync and execution
    task automatic cmd(logic [7:0] op, logic q, int x);
        QUAD_MODE = q;
        u_host_model.frame(op, q, x, rd);
        step(10);
    endtask : cmd
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial
    begin
        NRST = 1'b0;
        ev = 12'h0;
        QUAD_MODE = 1'b0;
        step(8);
        NRST = 1'b1;
        step(3);
        chk(STAT, 16'h01);
        cmd(OP_SREAD_DEF, 0, 16);
        chk(rd, 16'h0101);
        chk(SIO_OE, 16'h0);
        pls(12'h055);
        chk(STAT, 16'h6d);
        cmd(OP_SREAD_DEF, 1, 4);
        chk(rd, 16'h6d6d);
        pls(12'h0af);
        chk(STAT, 16'h01);
        // Suspend and resume in one cycle: the suspend must win
        pls(12'h0f0);
        chk(STAT, 16'h0d);
        pls(12'h0a0);
        chk(STAT, 16'h01);
        $display("test flags done");
        cmd(OP_ENTER_DEF, 1, 0);
        chk(OTPM, 16'h1);
        pls(12'he00);
        chk(g, 16'h3);
        pls(12'h200);
        chk(g, 16'h5);
        cmd(OP_EXIT_DEF, 0, 0);
        pls(12'h600);
        chk({OTPM, g}, 16'h4);
        cmd(OP_SWRITE_DEF, 0, 0);
        chk({rej_seen, STAT[1]}, 16'h2);
        cmd(OP_WRITE_ENABLE_CMD_DEF, 0, 0);
        cmd(OP_SWRITE_DEF, 0, 1);
        chk({rej_seen, STAT[1]}, 16'h2);
        cmd(OP_WRITE_ENABLE_CMD_DEF, 1, 0);
        cmd(OP_SWRITE_DEF, 1, 0);
        chk({rej_seen, STAT[1], WRITE_ENABLE_LATCH}, 16'h2);
        cmd(OP_ENTER_DEF, 0, 0);
        pls(12'h600);
        chk(g, 16'h3);
        cmd(OP_EXIT_DEF, 0, 0);
        pls(12'h100);
        chk(STAT, 16'h83);
        $display("test otp done");
        cmd(OP_WAKE, 0, 0);
        chk(DEEP, 16'h0);
        cmd(OP_DEEP, 0, 0);
        cmd(OP_SREAD_DEF, 0, 8);
        chk({rej_seen, DEEP}, 16'h3);
        // No status bits may leave the link while asleep
        chk(rd[7:0], 16'h0);
        QUAD_MODE = 1'b1;
        u_host_model.frame(OP_WAKE, 1, 0, rd);
        for (n = 0; n < 30 && DEEP !== 1'b0; n++)
            step(1);
        chk(n > 6 && n < 30, 16'h1);
        // A wake that never ends skips straight to the verdict
        if (n < 30)
        begin
            step(10);
            cmd(OP_SREAD_DEF, 0, 8);
            chk(rd[7:0], 16'h83);
            $display("test power done");
        end
        wrap_up;
    end
endmodule : otp_sec_status_tb
